// File: src/tel_pkg.sv
package tel_pkg;
  // clock and timing
  localparam int CLK_MHZ        = 25;
  localparam int ANA_OFF_US     = 30000;
  localparam int DIG_RST_US     = 125000;
  localparam int LED_WIDTH_US   = 31250;
  localparam int ANA_OFF_CYC    = ANA_OFF_US * CLK_MHZ;
  localparam int DIG_RST_CYC    = DIG_RST_US * CLK_MHZ;
  localparam int LED_WIDTH_CYC  = LED_WIDTH_US * CLK_MHZ;
  localparam int START_W        = 22;
  localparam int LED_W          = 20;
  // stuck bitstream observation window (clock / 128)
  localparam int STUCK_WIN_CYC  = 128;
  // phase compensation: one step of 0.038 deg at 50 Hz is 2111 ns
  localparam int PHASE_STEP_NS  = 2111;
  localparam int PHASE_STEP_CYC = (PHASE_STEP_NS * CLK_MHZ) / 1000;
  localparam int PHASE_MAX      = 15;
  localparam int PH_LEN         = PHASE_MAX * PHASE_STEP_CYC;
  localparam int PH_IDX_W       = 10;
  // measurement tick divider per clock band
  localparam logic [4:0] MEAS_DIV_LO = 5'h08;
  localparam logic [4:0] MEAS_DIV_HI = 5'h10;
  // tamper multiplex, in line periods
  localparam logic [5:0] SW_NORMAL  = 6'h20;
  localparam logic [5:0] SW_PRI_DOM = 6'h3C;
  localparam logic [5:0] SW_SEC_DOM = 6'h04;
  localparam logic [5:0] CMP_SPAN   = 6'h04;
  localparam logic [2:0] TAMPER_THRESHOLD_SELECT_LAST  = 3'h3;
  localparam int TAMPER_THRESHOLD_SELECT_SH_WIDE   = 4;
  localparam int TAMPER_THRESHOLD_SELECT_SH_NARROW = 5;
  localparam int E_W            = 24;
  localparam int ACC_W          = E_W + 3;
  // low-rate led dividers for divider settings 0..3
  localparam logic [8:0] LED_DIV [4] = '{9'h040, 9'h080, 9'h020, 9'h100};
  typedef enum logic {TS_NORMAL, TS_TAMPER} tel_tstate_t;
endpackage : tel_pkg

// File: src/tel_sd_chk.sv
`timescale 1ns/10ps
module tel_sd_chk import tel_pkg::*; (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_clr,
  input  wire logic i_sd,
  output logic      o_sd,
  output logic      o_stuck
);
  logic       s1, s2, s3, idle;
  logic [7:0] cnt, next_cnt;
  logic       next_stuck, next_sd;

  // run-length check; a stuck stream is replaced by a zero-mean 1010 pattern
  // until the raw stream moves again (comparing with the idle pattern would
  // release a stuck stream on every other cycle)
  always_comb begin
    next_cnt   = cnt;
    next_stuck = o_stuck;
    if (i_clr) begin
      next_cnt   = 8'h00;
      next_stuck = 1'h0;
    end else if (s2 != s3) begin
      next_cnt   = 8'h00; //RULE1
      next_stuck = 1'h0;
    end else if (cnt == 8'(STUCK_WIN_CYC - 1)) begin
      next_stuck = 1'h1; //RULE1
    end else begin
      next_cnt = cnt + 8'h01;
    end
    next_sd = next_stuck ? ~idle : s2; //RULE2
  end

  // synchroniser and state registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s1      <= 1'h0;
      s2      <= 1'h0;
      s3      <= 1'h0;
      idle    <= 1'h0;
      cnt     <= 8'h00;
      o_stuck <= 1'h0;
      o_sd    <= 1'h0;
    end else begin
      s1      <= i_sd;
      s2      <= s1;
      s3      <= s2;
      idle    <= ~idle;
      cnt     <= next_cnt;
      o_stuck <= next_stuck;
      o_sd    <= next_sd;
    end
  end
endmodule : tel_sd_chk

// File: src/tel_led.sv
`timescale 1ns/10ps
module tel_led import tel_pkg::*; #(
  parameter int WIDTH_CYC = LED_WIDTH_CYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clr,
  input  wire logic       i_hold,
  input  wire logic       i_pulse,
  input  wire logic       i_low_rate,
  input  wire logic [1:0] i_div_sel,
  output logic            o_led
);
  logic             tog, next_tog, next_led;
  logic [8:0]       div_cnt, next_div_cnt;
  logic [LED_W-1:0] wid, next_wid;

  // square wave at full rate, or divided fixed-width pulses at low rate
  always_comb begin
    next_tog     = tog;
    next_div_cnt = div_cnt;
    next_wid     = wid;
    if (i_clr || i_hold) begin
      next_tog     = 1'h0;
      next_div_cnt = 9'h000;
      next_wid     = '0;
    end else if (!i_low_rate) begin
      if (i_pulse) next_tog = ~tog; //RULE18
      next_wid = '0;
    end else begin
      if (wid != '0) next_wid = wid - LED_W'(1);
      if (i_pulse) begin
        if (div_cnt >= LED_DIV[i_div_sel] - 9'h001) begin //RULE19
          next_div_cnt = 9'h000;
          next_wid     = LED_W'(WIDTH_CYC); //RULE20
        end else begin
          next_div_cnt = div_cnt + 9'h001;
        end
      end
    end
    next_led = i_low_rate ? (next_wid != '0) : next_tog;
  end

  // registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tog     <= 1'h0;
      div_cnt <= 9'h000;
      wid     <= '0;
      o_led   <= 1'h0;
    end else begin
      tog     <= next_tog;
      div_cnt <= next_div_cnt;
      wid     <= next_wid;
      o_led   <= next_led;
    end
  end
endmodule : tel_led

// File: src/tel_core.sv
// How it works
// RULE1: every sigma-delta stream is watched for a 128-cycle constant run
// RULE2: a stuck stream is replaced by an idle zero-value pattern
// RULE3: pin levels of both stepper outputs and led are compared with drive
// RULE4: after reset, normal state, channels alternate 32:32 line periods
// RULE5: sample A is four primary periods, B the next four secondary
// RULE6: tamper criterion is difference above 12.5% or 6.25% of average
// RULE7: tamper entered after four consecutive true criterion results
// RULE8: tamper ratio is 60:4 or 4:60 towards the higher channel
// RULE9: in tamper no averaging; gap keeps higher channel for energy
// RULE10: opposite-sign energies force tamper, higher power channel used
// RULE11: single wire mode compares apparent energy instead of active
// RULE12: tamper flag drives the shared pin low
// RULE13: bad period, stuck stream or no load force normal and disable
// RULE14: voltage stream delayed by setting times 0.038 degree step
// RULE15: analog held off 30 ms and digital held reset 125 ms
// RULE16: reset clears every module including configuration shadows
// RULE17: clock band select sets the internal measurement divider
// RULE18: full rate led is a 50% square wave from energy pulses
// RULE19: low rate led divides by 64, 128, 32 or 256
// RULE20: low rate led pulses are 31.25 ms wide
// RULE21: no load suspends integration and disables tamper
// RULE22: frequency range error suspends power and holds outputs low
// RULE23: stuck stream or pin mismatch suspends integration while present
// RULE24: multiplex starts on primary with tamper pin released
`timescale 1ns/10ps
module tel_core import tel_pkg::*; #(
  parameter int ANA_OFF_CYCLES = ANA_OFF_CYC,
  parameter int DIG_RST_CYCLES = DIG_RST_CYC,
  parameter int LED_CYCLES     = LED_WIDTH_CYC
) (
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire logic                i_sd_volt,
  input  wire logic                i_sd_cur_pri,
  input  wire logic                i_sd_cur_sec,
  input  wire logic                i_line_tick,
  input  wire logic signed [E_W-1:0] i_pri_active,
  input  wire logic signed [E_W-1:0] i_sec_active,
  input  wire logic signed [E_W-1:0] i_pri_apparent,
  input  wire logic signed [E_W-1:0] i_sec_apparent,
  input  wire logic                i_single_wire,
  input  wire logic                i_tamper_threshold_select,
  input  wire logic [3:0]          i_phase_comp_setting,
  input  wire logic                i_clock_range_select,
  input  wire logic                i_low_rate_led_select,
  input  wire logic [1:0]          i_pulse_divider_select,
  input  wire logic                i_active_energy_pulse,
  input  wire logic                i_no_load_flag,
  input  wire logic                i_line_freq_range_error,
  input  wire logic                i_stepper_pos_int,
  input  wire logic                i_stepper_neg_int,
  input  wire logic                i_stepper_drive_pos_pin,
  input  wire logic                i_stepper_drive_neg_pin,
  input  wire logic                i_led_pin,
  input  wire logic                i_data_tamper_shared_pin,
  output logic                     o_data_tamper_shared_pin,
  output logic                     o_data_tamper_shared_pin_oe,
  output logic                     o_stepper_drive_pos,
  output logic                     o_stepper_drive_neg,
  output logic                     o_led,
  output logic                     o_sd_volt,
  output logic                     o_sd_cur_pri,
  output logic                     o_sd_cur_sec,
  output logic [2:0]               o_stuck_err,
  output logic                     o_pin_err,
  output logic                     o_integrate_en,
  output logic                     o_energy_sel_sec,
  output logic                     o_tamper,
  output logic                     o_meas_tick,
  output logic                     o_analog_on,
  output logic                     o_digital_run
);
  //////////////////////////////////////////////////////////////////////////////
  // start-up sequencing and configuration shadows
  logic [START_W-1:0] start_cnt, next_start_cnt;
  logic               next_analog_on, next_run;
  logic               cfg_thr, cfg_range, cfg_low, cfg_swm;
  logic [3:0]         cfg_ph;
  logic [1:0]         cfg_div;
  logic               clr;

  assign clr = !o_digital_run;

  // count from reset release; analog on first, digital later
  always_comb begin
    next_start_cnt = start_cnt;
    if (start_cnt != START_W'(DIG_RST_CYCLES)) next_start_cnt = start_cnt + START_W'(1);
    next_analog_on = next_start_cnt >= START_W'(ANA_OFF_CYCLES); //RULE15
    next_run       = next_start_cnt == START_W'(DIG_RST_CYCLES); //RULE15
  end

  // shadows stay cleared while the digital part is held in reset
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      start_cnt     <= '0;
      o_analog_on   <= 1'h0;
      o_digital_run <= 1'h0;
      cfg_thr       <= 1'h0; //RULE16
      cfg_range     <= 1'h0;
      cfg_low       <= 1'h0;
      cfg_swm       <= 1'h0;
      cfg_ph        <= 4'h0;
      cfg_div       <= 2'h0;
    end else begin
      start_cnt     <= next_start_cnt;
      o_analog_on   <= next_analog_on;
      o_digital_run <= next_run;
      cfg_thr       <= clr ? 1'h0 : i_tamper_threshold_select; //RULE16
      cfg_range     <= clr ? 1'h0 : i_clock_range_select;
      cfg_low       <= clr ? 1'h0 : i_low_rate_led_select;
      cfg_swm       <= clr ? 1'h0 : i_single_wire;
      cfg_ph        <= clr ? 4'h0 : i_phase_comp_setting;
      cfg_div       <= clr ? 2'h0 : i_pulse_divider_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stuck stream checks and phase delay
  logic             volt_clean, stuck_any;
  logic [PH_LEN-1:0] ph_sh;
  logic [PH_IDX_W-1:0] ph_idx;

  tel_sd_chk u_chk_volt (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clr(clr), //RULE1
    .i_sd(i_sd_volt), .o_sd(volt_clean), .o_stuck(o_stuck_err[0]));
  tel_sd_chk u_chk_pri (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clr(clr), //RULE2
    .i_sd(i_sd_cur_pri), .o_sd(o_sd_cur_pri), .o_stuck(o_stuck_err[1]));
  tel_sd_chk u_chk_sec (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clr(clr),
    .i_sd(i_sd_cur_sec), .o_sd(o_sd_cur_sec), .o_stuck(o_stuck_err[2]));

  assign stuck_any = |o_stuck_err;
  assign ph_idx    = PH_IDX_W'(cfg_ph) * PH_IDX_W'(PHASE_STEP_CYC) - PH_IDX_W'(1);

  // delay line on the voltage stream, tapped per compensation step
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_sh     <= '0;
      o_sd_volt <= 1'h0;
    end else begin
      ph_sh     <= {ph_sh[PH_LEN-2:0], volt_clean};
      o_sd_volt <= (cfg_ph == 4'h0) ? volt_clean : ph_sh[ph_idx]; //RULE14
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output drive, pin readback and measurement tick
  logic [2:0] rb_s1, rb_s2, drv_d1, drv_d2;
  logic       hold_step, next_pos, next_neg, next_integ, next_pin_err, led_int;
  logic [4:0] meas_cnt, next_meas_cnt;

  assign hold_step = i_line_freq_range_error | i_no_load_flag | clr;

  tel_led #(.WIDTH_CYC(LED_CYCLES)) u_led (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_clr(clr), .i_hold(i_line_freq_range_error), .i_pulse(i_active_energy_pulse), //RULE22
    .i_low_rate(cfg_low), .i_div_sel(cfg_div), .o_led(led_int));

  // next values of the drive, error and tick registers
  always_comb begin
    next_pos      = i_stepper_pos_int & ~hold_step; //RULE22
    next_neg      = i_stepper_neg_int & ~hold_step;
    next_pin_err  = !clr && (rb_s2 != drv_d2); //RULE3
    next_integ    = !clr && !i_no_load_flag && !i_line_freq_range_error //RULE21
                    && !stuck_any && !o_pin_err; //RULE23
    next_meas_cnt = meas_cnt + 5'h01;
    if (next_meas_cnt >= (cfg_range ? MEAS_DIV_HI : MEAS_DIV_LO)) next_meas_cnt = 5'h00; //RULE17
  end

  // registers; readback is compared against drive delayed by sync depth
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rb_s1 <= 3'h0;
      rb_s2 <= 3'h0;
      drv_d1 <= 3'h0;
      drv_d2 <= 3'h0;
      o_stepper_drive_pos <= 1'h0;
      o_stepper_drive_neg <= 1'h0;
      o_pin_err      <= 1'h0;
      o_integrate_en <= 1'h0;
      meas_cnt       <= 5'h00;
      o_meas_tick    <= 1'h0;
    end else begin
      rb_s1 <= {i_led_pin, i_stepper_drive_neg_pin, i_stepper_drive_pos_pin};
      rb_s2 <= rb_s1;
      drv_d1 <= {o_led, o_stepper_drive_neg, o_stepper_drive_pos};
      drv_d2 <= drv_d1;
      o_stepper_drive_pos <= next_pos;
      o_stepper_drive_neg <= next_neg;
      o_pin_err      <= next_pin_err;
      o_integrate_en <= next_integ;
      meas_cnt       <= next_meas_cnt;
      o_meas_tick    <= next_meas_cnt == 5'h00;
    end
  end
  assign o_led = led_int;

  //////////////////////////////////////////////////////////////////////////////
  // tamper detector
  tel_tstate_t              tstate, next_tstate;
  logic                     dom_sec, next_dom_sec, next_sel;
  logic [5:0]               per, next_per, sw;
  logic [2:0]               tamper_threshold_select_cnt, next_tamper_threshold_select_cnt;
  logic signed [ACC_W-1:0]  acc_a, acc_b, next_acc_a, next_acc_b, fin_b;
  logic [ACC_W-1:0]         mag_a, mag_b, diff, thr;
  logic [ACC_W:0]           sum;
  logic signed [E_W-1:0]    ea, eb;
  logic                     dis, eval, opp, tamper_threshold_select;

  assign dis  = i_line_freq_range_error | stuck_any | i_no_load_flag | clr; //RULE13
  assign sw   = (tstate == TS_NORMAL) ? SW_NORMAL : (dom_sec ? SW_SEC_DOM : SW_PRI_DOM); //RULE8
  assign ea   = cfg_swm ? i_pri_apparent : i_pri_active; //RULE11
  assign eb   = cfg_swm ? i_sec_apparent : i_sec_active;
  assign eval = i_line_tick && per == sw + CMP_SPAN - 6'h01; //RULE5
  assign fin_b = acc_b + ACC_W'(eb);
  assign mag_a = acc_a[ACC_W-1] ? ACC_W'(-acc_a) : ACC_W'(acc_a);
  assign mag_b = fin_b[ACC_W-1] ? ACC_W'(-fin_b) : ACC_W'(fin_b);
  assign opp   = (acc_a[ACC_W-1] != fin_b[ACC_W-1]) && acc_a != '0 && fin_b != '0;
  assign diff  = (mag_a > mag_b) ? mag_a - mag_b : mag_b - mag_a;
  assign sum   = {1'h0, mag_a} + {1'h0, mag_b};
  assign thr   = ACC_W'(cfg_thr ? (sum >> TAMPER_THRESHOLD_SELECT_SH_NARROW) : (sum >> TAMPER_THRESHOLD_SELECT_SH_WIDE)); //RULE6
  assign tamper_threshold_select  = diff > thr;

  // sampling windows around the switch point, then state decision
  always_comb begin
    next_tstate   = tstate;
    next_dom_sec  = dom_sec;
    next_per      = per;
    next_tamper_threshold_select_cnt = tamper_threshold_select_cnt;
    next_acc_a    = acc_a;
    next_acc_b    = acc_b;
    if (dis) begin
      next_tstate   = TS_NORMAL; //RULE13
      next_dom_sec  = 1'h0;
      next_per      = 6'h00; //RULE24
      next_tamper_threshold_select_cnt = 3'h0;
      next_acc_a    = '0;
      next_acc_b    = '0;
    end else if (i_line_tick) begin
      next_per = per + 6'h01; //RULE4
      if (per >= sw - CMP_SPAN && per < sw) next_acc_a = acc_a + ACC_W'(ea);
      if (6'(per - sw) < CMP_SPAN && !eval) next_acc_b = fin_b; // first three B periods only; fin_b adds the fourth at eval
      if (eval) begin
        next_acc_a = '0;
        next_acc_b = '0;
        if (opp) begin
          next_tstate   = TS_TAMPER; //RULE10
          next_dom_sec  = mag_b > mag_a;
          next_tamper_threshold_select_cnt = 3'h0;
        end else if (tstate == TS_NORMAL) begin
          next_tamper_threshold_select_cnt = tamper_threshold_select ? tamper_threshold_select_cnt + 3'h1 : 3'h0;
          if (tamper_threshold_select && tamper_threshold_select_cnt == TAMPER_THRESHOLD_SELECT_LAST) begin
            next_tstate   = TS_TAMPER; //RULE7
            next_dom_sec  = mag_b > mag_a;
            next_tamper_threshold_select_cnt = 3'h0;
          end
        end else if (tamper_threshold_select) begin
          next_dom_sec = mag_b > mag_a; //RULE9
        end else begin
          next_tstate = TS_NORMAL;
        end
        if (next_tstate != tstate || next_dom_sec != dom_sec) next_per = 6'h00;
      end
    end
    next_sel = (next_tstate == TS_TAMPER) ? next_dom_sec : (next_per >= SW_NORMAL); //RULE9
  end

  // tamper registers; pin is open drain, pulled low while tampered
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tstate   <= TS_NORMAL; //RULE4
      dom_sec  <= 1'h0;
      per      <= 6'h00;
      tamper_threshold_select_cnt <= 3'h0;
      acc_a    <= '0;
      acc_b    <= '0;
      o_energy_sel_sec <= 1'h0;
      o_tamper <= 1'h0;
    end else begin
      tstate   <= next_tstate;
      dom_sec  <= next_dom_sec;
      per      <= next_per;
      tamper_threshold_select_cnt <= next_tamper_threshold_select_cnt;
      acc_a    <= next_acc_a;
      acc_b    <= next_acc_b;
      o_energy_sel_sec <= next_sel;
      o_tamper <= next_tstate == TS_TAMPER;
    end
  end
  assign o_data_tamper_shared_pin    = 1'h0; //RULE12
  assign o_data_tamper_shared_pin_oe = o_tamper;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_ferr_holds_out: assert property (i_line_freq_range_error |=> //RULE22
    !o_stepper_drive_pos && !o_stepper_drive_neg && !o_integrate_en && !o_led)
    else $error("outputs not held low on frequency error");
  a_noload_suspend: assert property (i_no_load_flag |=> !o_integrate_en && !o_tamper) //RULE21
    else $error("no load did not suspend integration");
  a_stuck_forces: assert property (stuck_any |=> tstate == TS_NORMAL && !o_integrate_en) //RULE13
    else $error("stuck stream did not reset tamper");
  a_enter_four: assert property ($rose(o_tamper) |-> $past(tamper_threshold_select_cnt) == TAMPER_THRESHOLD_SELECT_LAST //RULE7
    || $past(opp)) else $error("tamper entered too early");
  a_tamper_pin: assert property (o_tamper |-> o_data_tamper_shared_pin_oe //RULE12
    && !o_data_tamper_shared_pin) else $error("tamper pin not driven low");
  a_period_stable: assert property (!i_line_tick && !dis |=> $stable(per) && $stable(tstate)) //RULE4
    else $error("multiplex moved without line tick");
  a_phase_zero: assert property (cfg_ph == 4'h0 |=> o_sd_volt == $past(volt_clean)) //RULE14
    else $error("zero phase setting delayed voltage");
  a_start_order: assert property (o_digital_run |-> o_analog_on) //RULE15
    else $error("digital released before analog");
  a_pin_mismatch: assert property (rb_s2 != drv_d2 && !clr |=> o_pin_err ##1 !o_integrate_en) //RULE3
    else $error("pin mismatch not flagged");
  c_tamper_entry: cover property ($rose(o_tamper));
  c_tamper_exit: cover property ($fell(o_tamper) && !dis);
  c_stuck_seen: cover property ($rose(stuck_any));
  c_led_low_rate: cover property (cfg_low && $rose(o_led));
endmodule : tel_core

// File: verif/tel_fe_model.sv
`timescale 1ns/10ps
module tel_fe_model (
  input  wire logic i_sys_clk,
  input  wire logic i_stuck,
  input  wire logic i_fault,
  input  wire logic i_pos,
  input  wire logic i_neg,
  input  wire logic i_led,
  output logic      o_sd_volt,
  output logic      o_sd_pri,
  output logic      o_sd_sec,
  output logic      o_pos_pin,
  output logic      o_neg_pin,
  output logic      o_led_pin
);
  logic [2:0] ph = 3'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // modulators keep busy patterns; a stuck primary sits high
  always_ff @(posedge i_sys_clk) ph <= ph + 3'h1;
  assign o_sd_volt = ph[2];
  assign o_sd_pri  = i_stuck | ph[1];
  assign o_sd_sec  = ph[0] ^ ph[2];
  // pins follow their drives; a shorted led pin reads inverted
  assign o_pos_pin = i_pos;
  assign o_neg_pin = i_neg;
  assign o_led_pin = i_led ^ i_fault;
endmodule : tel_fe_model

// File: verif/tel_core_tb.sv
`timescale 1ns/10ps
module tel_core_tb;
  import tel_pkg::*;
  localparam int ANA  = 300;
  localparam int DIG  = 1000;
  localparam int LEDC = 50;
  logic                  clk, rst, tick, swm, thr, rng, low, aep, nld, ferr, spi, sni;
  logic                  stuck, fault, sd_v, sd_p, sd_s, pp, np, lp;
  logic [3:0]            ph;
  logic [1:0]            dv;
  logic signed [E_W-1:0] pa, sa;
  logic                  o_pin_dat, o_oe, o_pos, o_neg, o_led, o_sdv, o_sdp, o_sds;
  logic                  o_pin_err, o_integ, o_sel_sec, o_tamper, o_mt, o_ana, o_run;
  logic [2:0]            o_stuck_err;
  int                    failures, comparisons, cyc, n;
  logic                  a;

  tel_core #(.ANA_OFF_CYCLES(ANA), .DIG_RST_CYCLES(DIG), .LED_CYCLES(LEDC)) u_tel_core (
    .i_sys_clk(clk), .i_rst(rst), .i_sd_volt(sd_v), .i_sd_cur_pri(sd_p), .i_sd_cur_sec(sd_s),
    .i_line_tick(tick), .i_pri_active(pa), .i_sec_active(sa), .i_pri_apparent(sa),
    .i_sec_apparent(pa), .i_single_wire(swm), .i_tamper_threshold_select(thr),
    .i_phase_comp_setting(ph), .i_clock_range_select(rng), .i_low_rate_led_select(low),
    .i_pulse_divider_select(dv), .i_active_energy_pulse(aep), .i_no_load_flag(nld),
    .i_line_freq_range_error(ferr), .i_stepper_pos_int(spi), .i_stepper_neg_int(sni),
    .i_stepper_drive_pos_pin(pp), .i_stepper_drive_neg_pin(np), .i_led_pin(lp),
    .i_data_tamper_shared_pin(o_pin_dat), .o_data_tamper_shared_pin(o_pin_dat),
    .o_data_tamper_shared_pin_oe(o_oe), .o_stepper_drive_pos(o_pos),
    .o_stepper_drive_neg(o_neg), .o_led(o_led), .o_sd_volt(o_sdv), .o_sd_cur_pri(o_sdp),
    .o_sd_cur_sec(o_sds), .o_stuck_err(o_stuck_err), .o_pin_err(o_pin_err),
    .o_integrate_en(o_integ), .o_energy_sel_sec(o_sel_sec), .o_tamper(o_tamper),
    .o_meas_tick(o_mt), .o_analog_on(o_ana), .o_digital_run(o_run));

  tel_fe_model u_tel_fe_model (
    .i_sys_clk(clk), .i_stuck(stuck), .i_fault(fault), .i_pos(o_pos), .i_neg(o_neg),
    .i_led(o_led), .o_sd_volt(sd_v), .o_sd_pri(sd_p), .o_sd_sec(sd_s), .o_pos_pin(pp),
    .o_neg_pin(np), .o_led_pin(lp));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic step(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse();
    aep = 1'b1;
    step();
    aep = 1'b0;
    step();
  endtask : pulse
  task automatic line_tick();
    tick = 1'b1;
    step();
    tick = 1'b0;
    step();
  endtask : line_tick
  task automatic wrap_up();
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    step(8);
    chk({o_ana, o_run, o_tamper, o_oe, o_led}, 0);
    rst = 1'b0;
    for (n = 1; n < 2000 && o_ana !== 1'b1; n++) step();
    chk(n - 1, ANA);
    for (; n < 2000 && o_run !== 1'b1; n++) step();
    chk(n - 1, DIG);
    chk({o_oe, o_tamper, o_sel_sec}, 0);
    step(2);
  endtask : t_reset
  task automatic t_led_low();
    repeat (31) pulse();
    chk(o_led, 0);
    pulse();
    chk(o_led, 1);
    step(LEDC - 4);
    chk(o_led, 1);
    step(8);
    chk(o_led, 0);
    dv = 2'h0;
    repeat (63) pulse();
    chk(o_led, 0);
    pulse();
    chk(o_led, 1);
  endtask : t_led_low
  task automatic t_led_full();
    low = 1'b0;
    step(2);
    repeat (3) begin
      a = o_led;
      pulse();
      chk(o_led, !a);
    end
  endtask : t_led_full
  task automatic t_errors();
    stuck = 1'b1;
    step(120);
    chk(o_stuck_err, 3'h0);
    step(20);
    chk(o_stuck_err, 3'h2);
    chk(o_integ, 0);
    a = o_sdp;
    step();
    chk(o_sdp, !a);
    stuck = 1'b0;
    step(12);
    chk({o_stuck_err, o_integ}, 1);
    fault = 1'b1;
    step(6);
    chk({o_pin_err, o_integ}, 2);
    fault = 1'b0;
    step(8);
    chk({o_pin_err, o_integ}, 1);
  endtask : t_errors
  task automatic t_tamper();
    pa = 24'sd1000;
    sa = 24'sd2000;
    for (n = 1; n <= 300; n++) begin
      line_tick();
      if (n == 31 || n == 65) chk(o_sel_sec, 0);
      if (n == 33) chk(o_sel_sec, 1);
      if (o_tamper === 1'b1) break;
    end
    chk(n, 228);
    chk({o_oe, o_pin_dat, o_sel_sec}, 3'h5);
    {nld, swm} = 2'h3;
    step(3);
    chk({o_tamper, o_oe, o_integ, o_pos}, 0);
    nld = 1'b0;
    pa = 24'sd2000;
    sa = -24'sd1000;
    for (n = 1; n < 40 && o_tamper !== 1'b1; n++) line_tick();
    chk({o_tamper, o_sel_sec}, 3);
  endtask : t_tamper
  task automatic t_freq();
    if (o_led !== 1'b1) pulse();
    chk({o_pos, o_neg, o_led}, 3'h7);
    ferr = 1'b1;
    step(3);
    chk({o_pos, o_neg, o_led}, 0);
  endtask : t_freq
  // tick period per clock band, counted over a 64-cycle window
  task automatic t_tick();
    for (int r = 0; r < 2; r++) begin
      rng = r[0];
      step(40);
      n = 0;
      repeat (64) begin
        step();
        n += o_mt;
      end
      chk(n, 64 / (r ? MEAS_DIV_HI : MEAS_DIV_LO));
    end
  endtask : t_tick
  // period-8 voltage stream: 4-cycle path inverts it, one extra step restores it
  task automatic t_phase();
    repeat (2) begin
      step(60);
      chk(o_sdv, ph ? sd_v : !sd_v);
      ph = 4'h1;
    end
  endtask : t_phase

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst, low} = 2'h3;
    {tick, swm, thr, rng, aep, nld, ferr, spi, sni, stuck, fault} = 11'h000;
    ph = 4'h0;
    dv = 2'h2;
    pa = 24'sd0;
    sa = 24'sd0;
    {failures, comparisons, cyc} = 0;
    t_reset();
    t_led_low();
    t_led_full();
    {spi, sni} = 2'h3;
    t_errors();
    t_tamper();
    t_freq();
    t_tick();
    t_phase();
    wrap_up();
  end
endmodule : tel_core_tb
